/* File: dac_serial_cmd.sv */
// Purpose: Serial command decoder and update control for a sixteen-channel converter.
// Assumes: Link pins asynchronous, sampled at 40 MHz; link clock well below a quarter of that.
// Notes:   Registers over APB, zero wait states.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps

module dac_serial_cmd
    import dac_cmd_pkg::*;
#(
    parameter logic [15:0] CONV_CYCLES = 16'(CONV_CYC),
    parameter logic [15:0] FINE_CYCLES = 16'(FINE_CYC),
    parameter logic [15:0] CAL_CYCLES = 16'(CAL_CYC)
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register bus
    input wire apb_req_t apb_i,
    output apb_rsp_t apb_o,
    // Serial link
    input wire link_in_t link_i,
    output logic dout_o,
    output logic busy_n_o,
    // Channel values to the converters
    output logic [CHANS-1:0][VAL_BITS-1:0] codes_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    state_t st;                     // Whole module state
    state_t st_nxt;                 // Next state
    logic sync_fall;                // Frame start seen
    logic sync_rise;                // Frame end seen
    logic sclk_fall;                // Shift edge seen
    logic sclk_rise;                // Ripple-out edge seen
    logic busy;                     // Conversion, fine update or calibration running
    logic [1:0] w_op;               // Operation field of held word
    logic [3:0] w_ch;               // Channel field of held word
    logic [CODE_BITS-1:0] w_data;   // Data field of held word
    logic [STEP_BITS-1:0] w_step;   // Fine-adjust count
    logic [VAL_BITS:0] fine_sum;    // One extra bit to catch overflow
    logic setup_ph;                 // APB setup cycle
    logic access_ph;                // APB access cycle
    logic [31:0] rd_val;            // Read data chosen at setup

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    // Bus answers at once; read data was latched in the setup cycle
    assign apb_o.pready = 1'b1;
    assign apb_o.prdata = st.prdata;
    assign apb_o.pslverr = st.pslverr;
    assign dout_o = st.dout;
    assign busy_n_o = ~busy;
    assign codes_o = st.code;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // All decode, shifting, timing and bus access in one place
    always_comb
    begin
        st_nxt = st;
        st_nxt.go = 1'b0;
        // Two-stage synchronisers; only the second stage feeds logic
        st_nxt.sync_q = {st.sync_q[1], st.sync_q[0], link_i.sync_n};
        st_nxt.sclk_q = {st.sclk_q[1], st.sclk_q[0], link_i.sclk};
        st_nxt.din_q = {st.din_q[0], link_i.din};
        // Edge detect on second stage against its previous value
        sync_fall = st.sync_q[2] & ~st.sync_q[1];
        sync_rise = ~st.sync_q[2] & st.sync_q[1];
        // Sampling the clock rather than clocking on it copes with gaps and bursts alike
        sclk_fall = st.sclk_q[2] & ~st.sclk_q[1];
        sclk_rise = ~st.sclk_q[2] & st.sclk_q[1];
        busy = (st.ph != PH_IDLE);
        // Field split of the held word
        w_op = st.sh[OP_MSB:OP_LSB];
        w_ch = st.sh[CH_MSB:CH_LSB];
        w_data = st.sh[DATA_MSB:0];
        w_step = st.sh[STEP_BITS-1:0];
        fine_sum = '0;
        setup_ph = apb_i.psel & ~apb_i.penable;
        access_ph = apb_i.psel & apb_i.penable;
        rd_val = '0;

        // Frame handling
        if (sync_fall)
        begin
            // New frame: counter restarts and shifting is allowed again
            st_nxt.cnt = '0;
            st_nxt.armed = 1'b1;
        end
        else if (sync_rise)
        begin
            if (st.armed && st.chain_en && (st.cnt == WORD_CNT) && !busy)
            begin
                st_nxt.go = 1'b1;
            end
            else if (st.armed && (st.cnt != WORD_CNT))
            begin
                // Short frame: dropped, channel untouched
                st_nxt.aborts = st.aborts + 8'h01;
            end
            st_nxt.armed = 1'b0;
        end
        else if (sclk_fall && st.armed && !st.sync_q[1] && !busy)
        begin
            // MSB first into the bottom of the shift register
            st_nxt.sh = {st.sh[WORD_BITS-2:0], st.din_q[1]};
            if (st.chain_en)
            begin
                // No gating: extra bits ripple through, counter saturates
                if (st.cnt != WORD_CNT)
                begin
                    st_nxt.cnt = st.cnt + 5'h01;
                end
            end
            else
            begin
                st_nxt.cnt = st.cnt + 5'h01;
                if (st.cnt + 5'h01 == WORD_CNT)
                begin
                    // Word complete: execute and gate further clocks
                    st_nxt.go = 1'b1;
                    st_nxt.armed = 1'b0;
                end
            end
        end
        // Busy discards any clock edge, the host is only advised to hold off

        // Ripple-out launches on the rising serial clock edge
        if (!st.chain_en)
        begin
            st_nxt.dout = 1'b0;
        end
        else if (sclk_rise)
        begin
            st_nxt.dout = st.sh[WORD_BITS-1];
        end

        // Phase timer runs down and releases busy at zero
        if (busy)
        begin
            if (st.tmr == '0)
            begin
                st_nxt.ph = PH_IDLE;
            end
            else
            begin
                st_nxt.tmr = st.tmr - 16'h0001;
            end
        end

        // Command execution
        if (st.go)
        begin
            st_nxt.last_op = w_op;
            st_nxt.last_ch = w_ch;
            unique case (op_t'(w_op))
                OP_LOAD:
                begin
                    // Load clears the quarter bits
                    st_nxt.code[w_ch] = {w_data, FRAC_ZERO};
                    st_nxt.ph = PH_CONV;
                    st_nxt.tmr = CONV_CYCLES - 16'h0001;
                end
                OP_INC:
                begin
                    fine_sum = {1'b0, st.code[w_ch]} + (VAL_BITS+1)'(w_step);
                    // Saturate at top of scale
                    st_nxt.code[w_ch] = fine_sum[VAL_BITS] ? MAX_CODE : fine_sum[VAL_BITS-1:0];
                    st_nxt.ph = PH_FINE;
                    st_nxt.tmr = FINE_CYCLES - 16'h0001;
                end
                OP_DEC:
                begin
                    fine_sum = {1'b0, st.code[w_ch]} - (VAL_BITS+1)'(w_step);
                    // Borrow means below bottom; clamp to zero
                    st_nxt.code[w_ch] = fine_sum[VAL_BITS] ? '0 : fine_sum[VAL_BITS-1:0];
                    st_nxt.ph = PH_FINE;
                    st_nxt.tmr = FINE_CYCLES - 16'h0001;
                end
                OP_NOP:
                begin
                    // Data ignored; address only recorded in last_ch
                    st_nxt.ph = st.ph;
                end
            endcase
        end

        // Bus setup: choose read data and error answer ahead of access
        if (setup_ph)
        begin
            st_nxt.pslverr = 1'b0;
            if (apb_i.paddr == CTRL_OFS)
            begin
                rd_val[CTRL_CHAIN_BIT] = st.chain_en;
            end
            else if (apb_i.paddr == STAT_OFS && !apb_i.pwrite)
            begin
                rd_val = {16'h0000, st.aborts, st.last_ch, st.last_op, st.armed, busy};
            end
            else if ((apb_i.paddr[ADDR_W-1:6] == CHAN_BASE[ADDR_W-1:6]) && (apb_i.paddr[1:0] == 2'h0)
                     && !apb_i.pwrite)
            begin
                rd_val[VAL_BITS-1:0] = st.code[apb_i.paddr[5:2]];
            end
            else
            begin
                // Unmapped or read-only target
                st_nxt.pslverr = 1'b1;
            end
            st_nxt.prdata = rd_val;
        end

        // Bus access: writes land on the completing edge
        if (access_ph && apb_i.pwrite && (apb_i.paddr == CTRL_OFS))
        begin
            st_nxt.chain_en = apb_i.pwdata[CTRL_CHAIN_BIT];
            // Calibration only starts from a quiet block; a word finishing in this
            // same cycle wins and the calibration request is dropped, as its update would otherwise cut calibration short
            if (apb_i.pwdata[CTRL_CAL_BIT] && !busy && !st.go && !st_nxt.go)
            begin
                st_nxt.ph = PH_CAL;
                st_nxt.tmr = CAL_CYCLES - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset puts every channel at mid-scale
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            st <= '0;
            st.sync_q <= '1;
            st.sclk_q <= '1;
            st.ph <= PH_IDLE;
            st.code <= {CHANS{MID_CODE}};
        end
        else
        begin
            st <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Busy-low length counter, read only by the checks
    logic [15:0] low_cnt;
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || !busy)
        begin
            low_cnt <= '0;
        end
        else
        begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    // All checks share the system clock and sleep through reset, except the reset check
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_conv_length: assert property ($rose(busy_n_o) && $past(st.ph) == PH_CONV |-> low_cnt == CONV_CYCLES)
        else $error("conversion busy length wrong");
    a_fine_length: assert property ($rose(busy_n_o) && $past(st.ph) == PH_FINE |-> low_cnt == FINE_CYCLES)
        else $error("fine update busy length wrong");
    a_busy_ignores: assert property (!busy_n_o && sclk_fall |=> $stable(st.sh))
        else $error("shift register moved while busy");
    a_frame_clear: assert property (sync_fall |=> st.cnt == 5'h00 && st.armed)
        else $error("frame start did not clear counter");
    a_load_value: assert property (st.go && w_op == OP_LOAD
        |=> st.code[$past(w_ch)] == {$past(w_data), FRAC_ZERO} && !busy_n_o)
        else $error("full load value or busy wrong");
    a_nop_keeps: assert property (st.go && w_op == OP_NOP |=> $stable(st.code) && busy_n_o)
        else $error("no-operation changed state");
    a_abort_keeps: assert property (sync_rise && st.armed && st.cnt != WORD_CNT
        |=> !st.go ##1 $stable(st.code))
        else $error("short frame changed a channel");
    a_cal_busy: assert property (access_ph && apb_i.pwrite && apb_i.paddr == CTRL_OFS
        && apb_i.pwdata[CTRL_CAL_BIT] && busy_n_o && !st.go && !st_nxt.go |=> !busy_n_o [*8])
        else $error("calibration did not hold busy");
    // Reset check keeps its own disable, since it watches reset itself
    a_reset_mid: assert property (@(posedge clock_i) disable iff (1'b0)
        !nrst_i |=> st.code == {CHANS{MID_CODE}})
        else $error("channels not at reset value");
    a_inc_step: assert property (st.go && w_op == OP_INC
        && {1'b0, st.code[w_ch]} + 15'(w_step) <= 15'(MAX_CODE)
        |=> st.code[$past(w_ch)] == $past(st.code[w_ch]) + 14'($past(w_step)))
        else $error("increment step wrong");

    // Frame gating and step checks
    // Below-zero results clamp; an in-range decrement moves by exactly the step
    a_dec_step: assert property (st.go && w_op == OP_DEC && {1'b0, st.code[w_ch]} >= 15'(w_step)
        |=> st.code[$past(w_ch)] == $past(st.code[w_ch]) - 14'($past(w_step)))
        else $error("decrement step wrong");
    // A standalone word runs on its last falling edge, not on frame end
    a_word_exec: assert property (sclk_fall && !sync_fall && st.armed && !st.sync_q[1] && !busy
        && !st.chain_en && st.cnt == WORD_CNT - 5'h01 |=> st.go)
        else $error("complete word not executed");
    // In chain mode the bit count alone never starts a word
    a_chain_hold: assert property (st.chain_en && !sync_rise |=> !st.go)
        else $error("chain word ran before frame end");
    // Once a word is taken, later clocks shift nothing until a new frame starts;
    // this is what keeps a long burst from corrupting the next word
    a_gate_clock: assert property (!st.armed && !sync_fall |=> $stable(st.sh))
        else $error("shift register moved outside a frame");

endmodule // dac_serial_cmd

/* File: dac_cmd_pkg.sv */
// Purpose: Shared constants, encodings and carrier types for the serial command front end.
// Assumes: 40 MHz system clock; link pins are asynchronous to it.
// Notes:   All timing counts derive from times in their own unit.
package dac_cmd_pkg;

    // ----------------------------------------------------------------
    // Command word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 18;          // Bits per command word
    localparam int CHANS = 16;              // Output channels
    localparam int CODE_BITS = 12;          // Full-code data width
    localparam int FRAC_BITS = 2;           // Quarter-step bits
    localparam int VAL_BITS = CODE_BITS + FRAC_BITS;
    localparam int STEP_BITS = 7;           // Fine-adjust step count width
    localparam int OP_MSB = 17;
    localparam int OP_LSB = 16;
    localparam int CH_MSB = 15;
    localparam int CH_LSB = 12;
    localparam int DATA_MSB = 11;
    localparam logic [4:0] WORD_CNT = 5'h12; // Falling edges per word
    localparam logic [VAL_BITS-1:0] MID_CODE = 14'h2000; // Mid-scale, zero volts
    localparam logic [VAL_BITS-1:0] MAX_CODE = 14'h3FFF;
    localparam logic [FRAC_BITS-1:0] FRAC_ZERO = 2'h0;

    // Operation field encodings
    typedef enum logic [1:0] {
        OP_LOAD = 2'h0,
        OP_INC = 2'h1,
        OP_DEC = 2'h2,
        OP_NOP = 2'h3
    } op_t;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int CONV_TIME_NS = 25000;    // Full-code conversion, typical
    localparam int FINE_TIME_NS = 1000;     // Fine-adjust update
    localparam int CAL_TIME_NS = 25000;     // Self-calibration
    localparam int CONV_CYC = CONV_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int FINE_CYC = FINE_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int CAL_CYC = CAL_TIME_NS / (1_000_000_000 / CLK_HZ);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] CHAN_BASE = 12'h040;
    localparam int CTRL_CHAIN_BIT = 0;
    localparam int CTRL_CAL_BIT = 1;

    // ----------------------------------------------------------------
    // Carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic sync_n;   // Frame select, active low
        logic sclk;     // Serial clock
        logic din;      // Serial data
    } link_in_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CONV,
        PH_FINE,
        PH_CAL
    } phase_t;

    typedef struct packed {
        logic [2:0] sync_q;     // [0] first stage, [1] second, [2] previous
        logic [2:0] sclk_q;
        logic [1:0] din_q;
        logic armed;
        logic [4:0] cnt;
        logic [WORD_BITS-1:0] sh;
        logic go;
        logic dout;
        phase_t ph;
        logic [15:0] tmr;
        logic chain_en;
        logic [1:0] last_op;
        logic [3:0] last_ch;
        logic [7:0] aborts;
        logic [31:0] prdata;
        logic pslverr;
        logic [CHANS-1:0][VAL_BITS-1:0] code;
    } state_t;

endpackage

/* File: dac_link_host.sv */
// Purpose: Behavioural host that drives the three-wire command link.
// Assumes: Link clock period of 200 ns, built from eight system clocks.
// Notes:   Link clock idles high and stands still between frames.
`timescale 1ns/100ps

module dac_link_host
    import dac_cmd_pkg::*;
(
    // Clock, busy and chain output feedback
    input wire logic clock_i,
    input wire logic busy_n_i,
    input wire logic dout_i,
    // Link pins
    output link_in_t link_o
);
    // Idle frame select high, clock high
    initial link_o = '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0};
    logic [2*WORD_BITS-1:0] rx; // Chain output seen at each falling edge, newest in bit 0

    // ----------------------------------------------------------------
    // Frame of n bits of w, MSB first; polite frames wait out busy
    // ----------------------------------------------------------------
    task automatic frame(input logic [2*WORD_BITS-1:0] w, input int n, input bit polite);
        int i;
        if (polite)
        begin
            while (busy_n_i !== 1'b1) @(posedge clock_i);
        end
        @(posedge clock_i);
        link_o.sync_n <= 1'b0;
        repeat (4) @(posedge clock_i);
        for (i = n - 1; i >= 0; i--)
        begin
            // Data set while clock high, taken at the fall
            link_o.din <= w[i];
            repeat (4) @(posedge clock_i);
            rx = {rx[2*WORD_BITS-2:0], dout_i};
            link_o.sclk <= 1'b0;
            repeat (4) @(posedge clock_i);
            link_o.sclk <= 1'b1;
        end
        repeat (4) @(posedge clock_i);
        link_o.sync_n <= 1'b1;
        // Released data line must not look like the last bit
        link_o.din <= ~link_o.din;
        repeat (16) @(posedge clock_i);
    endtask
endmodule // dac_link_host

/* File: multichannel_dac_serial_command_bench.sv */
// Purpose: Self-checking bench for the serial command front end.
// Assumes: Shortened conversion and calibration busy counts; expectations follow those values.
// Notes:   Channel changes and read data are matched against queued notes.
`timescale 1ns/100ps

module multichannel_dac_serial_command_bench;
    import dac_cmd_pkg::*;
    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam logic [15:0] CONV_P = 16'h0190; // Long enough to hold a whole ignored frame
    localparam logic [15:0] FINE_P = 16'h0028;
    localparam logic [15:0] CAL_P = 16'h0190;
    localparam int LIMIT = 60000;
    typedef struct { logic [32:0] exp; logic [32:0] mask; string what; } note_t;
    logic clock_i, nrst_i, dout_o, busy_n_o;
    apb_req_t apb_i;
    apb_rsp_t apb_o;
    link_in_t link_i;
    logic [CHANS-1:0][VAL_BITS-1:0] codes_o, prev_codes;
    logic [VAL_BITS-1:0] model [CHANS];
    logic [3:0] ch;
    logic [11:0] d;
    note_t rd_q[$], code_q[$], n;
    int mismatches, tests_run, cycles;

    dac_serial_cmd #(.CONV_CYCLES(CONV_P), .FINE_CYCLES(FINE_P), .CAL_CYCLES(CAL_P)) u_dac_serial_cmd (
        .clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o), .link_i(link_i),
        .dout_o(dout_o), .busy_n_o(busy_n_o), .codes_o(codes_o));
    dac_link_host u_dac_link_host (.clock_i(clock_i), .busy_n_i(busy_n_o), .dout_i(dout_o), .link_o(link_i));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] seen, input logic [32:0] m);
        tests_run++;
        if (((seen ^ exp) & m) !== 33'h0)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp & m, seen & m);
        end
    endtask

    function automatic logic [17:0] word(input op_t op, input logic [3:0] c, input logic [11:0] v);
        return {op, c, v};
    endfunction

    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock_i);
        apb_i.penable <= 1'b1;
        @(posedge clock_i);
        // Only the bench timeout ends this wait
        while (apb_o.pready !== 1'b1)
        begin
            @(posedge clock_i);
        end
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        @(posedge clock_i);
    endtask

    // Read with a note of {pslverr, prdata} for the watcher
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] exp, input logic [32:0] m, input string what);
        rd_q.push_back('{exp, m, what});
        apb(1'b0, a, 32'h0);
    endtask

    // Note a channel change only when the value really moves
    task automatic expect_code(input logic [3:0] c, input logic [VAL_BITS-1:0] v);
        if (model[c] !== v)
            code_q.push_back('{{15'h0, c, v}, {33{1'b1}}, "channel value"});
        model[c] = v;
    endtask

    // Length of the next busy period, allowing one cycle of slack
    task automatic busy_len(input int exp);
        int w, k;
        w = 0;
        k = 0;
        while (busy_n_o !== 1'b0 && w < 2000)
        begin
            w++;
            @(posedge clock_i);
        end
        while (busy_n_o === 1'b0 && k < 3000)
        begin
            k++;
            @(posedge clock_i);
        end
        check("busy low cycles near", 33'(exp), 33'(k), (k >= exp - 1 && k <= exp + 1) ? 33'h0 : {33{1'b1}});
    endtask

    // ----------------------------------------------------------------
    // Clock, timeout and result watcher
    // ----------------------------------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            complete_run();
        end
    end

    // Each result that appears takes the oldest note off its queue
    always @(posedge clock_i)
    begin
        prev_codes <= codes_o;
        if (nrst_i === 1'b1 && apb_i.psel && apb_i.penable && !apb_i.pwrite && apb_o.pready === 1'b1)
        begin
            if (rd_q.size() == 0)
                check("unexpected read", 33'h0, 33'h1, 33'h1);
            else
            begin
                n = rd_q.pop_front();
                check(n.what, n.exp, {apb_o.pslverr, apb_o.prdata}, n.mask);
            end
        end
        for (int c = 0; c < CHANS; c++)
        begin
            if (nrst_i === 1'b1 && codes_o[c] !== prev_codes[c])
            begin
                if (code_q.size() == 0)
                    n = '{33'h1FFFFFFFF, {33{1'b1}}, "unexpected change"};
                else
                    n = code_q.pop_front();
                check(n.what, n.exp, {15'h0, 4'(c), codes_o[c]}, n.mask);
            end
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        nrst_i = 1'b0;
        apb_i = '0;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        for (int c = 0; c < CHANS; c++)
            model[c] = MID_CODE;
        void'($urandom(23026));
        repeat (12) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        for (int c = 0; c < CHANS; c++)
            check("reset code", 33'(MID_CODE), 33'(codes_o[c]), 33'h3FFF);
        check("idle busy and chain out", 33'h2, {31'h0, busy_n_o, dout_o}, 33'h3);
        // Frame cut after ten bits leaves codes alone and counts an abort
        u_dac_link_host.frame(36'(word(OP_LOAD, 4'h1, 12'hFFF) >> 8), 10, 1'b1);
        rd(STAT_OFS, 33'h000000100, 33'h00000FF00, "abort count");
        // Load, then a second frame sent into the busy period is ignored
        expect_code(4'h5, {12'hABC, FRAC_ZERO});
        fork
            begin
                u_dac_link_host.frame(36'(word(OP_LOAD, 4'h5, 12'hABC)), 18, 1'b1);
                u_dac_link_host.frame(36'(word(OP_LOAD, 4'h6, 12'h456)), 18, 1'b0);
            end
            busy_len(CONV_P);
        join
        // Fine adjust up by the largest count, then down by one
        expect_code(4'h5, 14'h2B6F);
        fork
            u_dac_link_host.frame(36'(word(OP_INC, 4'h5, 12'h07F)), 18, 1'b1);
            busy_len(FINE_P);
        join
        expect_code(4'h5, 14'h2B6E);
        fork
            u_dac_link_host.frame(36'(word(OP_DEC, 4'h5, 12'hF81)), 18, 1'b1);
            busy_len(FINE_P);
        join
        // No-operation with all data bits set changes nothing
        u_dac_link_host.frame(36'(word(OP_NOP, 4'h5, 12'hFFF)), 18, 1'b1);
        check("busy after no-op", 33'h1, 33'(busy_n_o), 33'h1);
        check("quiet chain out", 33'h0, 33'(u_dac_link_host.rx[WORD_BITS-1:0]), {33{1'b1}});
        // Random loads, both end channels included, read back over the bus
        for (int i = 0; i < 6; i++)
        begin
            ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            d = 12'($urandom);
            expect_code(ch, {d, FRAC_ZERO});
            fork
                u_dac_link_host.frame(36'(word(OP_LOAD, ch, d)), 18, 1'b1);
                busy_len(CONV_P);
            join
            rd(CHAN_BASE + 12'(4 * ch), {19'h0, model[ch]}, 33'h100003FFF, "channel readback");
        end
        // Chain mode: first word ripples through, second runs on the rise
        apb(1'b1, CTRL_OFS, 32'h1);
        rd(CTRL_OFS, 33'h1, 33'h100000001, "chain enable");
        expect_code(4'h2, {12'h5A5, FRAC_ZERO});
        fork
            u_dac_link_host.frame({word(OP_LOAD, 4'h1, 12'h111), word(OP_LOAD, 4'h2, 12'h5A5)}, 36, 1'b1);
            busy_len(CONV_P);
        join
        check("rippled word", 33'(word(OP_LOAD, 4'h1, 12'h111)), 33'(u_dac_link_host.rx[WORD_BITS-1:0]), {33{1'b1}});
        apb(1'b1, CTRL_OFS, 32'h0);
        // Calibration holds busy and swallows a write
        apb(1'b1, CTRL_OFS, 32'h2);
        fork
            busy_len(CAL_P);
            u_dac_link_host.frame(36'(word(OP_LOAD, 4'h3, 12'h777)), 18, 1'b0);
        join
        // Unmapped address is refused
        rd(12'h020, 33'h100000000, 33'h100000000, "unmapped read error");
        repeat (20) @(posedge clock_i);
        check("pending notes", 33'h0, 33'(code_q.size() + rd_q.size()), {33{1'b1}});
        complete_run();
    end
endmodule // multichannel_dac_serial_command_bench
